// *** logic/clc_core_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "clc_cfg.svh"
module clc_core_ctl
  import clc_pkg::*;
#(
  parameter logic [63:0] RESET_PC = `CLC_RESET_PC,
  parameter logic [63:0] EXC_VECTOR = `CLC_EXC_VECTOR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode64_pin,
  output logic fetch_req,
  output logic [63:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_word,
  output logic [63:0] xlat_vaddr,
  input wire logic xlat_hit,
  input wire logic [63:0] xlat_paddr,
  input wire logic xlat_cacheable,
  output logic mem_req,
  output logic mem_we,
  output logic [63:0] mem_addr,
  output logic [7:0] mem_be,
  output logic [63:0] mem_wdata,
  output logic mem_cacheable,
  output logic mem_fill,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  output logic exc_valid,
  output logic [4:0] exc_code,
  output logic exc_in_slot,
  output logic [63:0] exception_return_address,
  output logic retire_valid,
  output logic [63:0] retire_pc
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  clc_state_t state_reg; // Sequencer state
  clc_state_t state_next;
  logic m64_s1_reg; // Mode pin synchroniser, first stage
  logic m64_reg; // Mode pin synchroniser, second stage
  logic [63:0] pc_reg; // Address of current instruction
  logic [31:0] ir_reg; // Current instruction word
  logic slot_reg; // Current instruction sits in a delay slot
  logic [63:0] slot_tgt_reg; // Where to go after the slot
  logic [63:0] slot_bpc_reg; // Address of the branch owning the slot
  logic ld_pend_reg; // A load is still outstanding
  logic [4:0] ld_rt_reg; // Destination of the outstanding load
  logic op_store_reg; // Memory op in flight is a store
  logic [2:0] op_type_reg; // Access-type code of that op
  logic [63:0] st_data_reg; // Store data, right-aligned
  logic [63:0] gpr_mem [0:31]; // General register file

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [5:0] opc = ir_reg[31:26];
  wire [4:0] rs_f = ir_reg[25:21];
  wire [4:0] rt_f = ir_reg[20:16];
  wire [4:0] rd_f = ir_reg[15:11];
  wire [5:0] fn_f = ir_reg[5:0];
  wire [63:0] imm_sx = {{48{ir_reg[15]}}, ir_reg[15:0]};
  wire is_special = (opc == `CLC_OPC_SPECIAL);
  wire is_add = is_special && (fn_f == `CLC_FN_ADD);
  wire is_jr = is_special && (fn_f == `CLC_FN_JR);
  wire is_jalr = is_special && (fn_f == `CLC_FN_JALR);
  wire is_j = (opc == `CLC_OPC_J);
  wire is_jal = (opc == `CLC_OPC_JAL);
  wire is_beq = (opc == `CLC_OPC_BEQ);
  wire is_bne = (opc == `CLC_OPC_BNE);
  wire is_load = (opc[5:3] == `CLC_LD_GROUP);
  wire is_store = (opc[5:3] == `CLC_ST_GROUP);
  wire is_scu = (opc == `CLC_OPC_SCU);
  wire is_mf = is_scu && (rs_f == `CLC_SCU_MF);
  wire is_mt = is_scu && (rs_f == `CLC_SCU_MT);
  // Coprocessor load/store forms never reach control unit registers
  wire is_copmem = (opc[5:4] == `CLC_COPMEM_GROUP);
  wire is_branch = is_jr || is_jalr || is_j || is_jal || is_beq || is_bne;
  wire is_link = is_jal || is_jalr;
  wire known = is_add || is_branch || is_load || is_store || is_mf || is_mt || is_copmem;

  // ----------------------------------------------------------------
  // Operand read and arithmetic
  // ----------------------------------------------------------------
  // Register zero always reads as zero
  wire [63:0] rs_val = (rs_f == 5'h00) ? 64'h0 : gpr_mem[rs_f];
  wire [63:0] rt_val = (rt_f == 5'h00) ? 64'h0 : gpr_mem[rt_f];
  // Low 31 bits first, to expose the carry out of bit 30
  wire [31:0] lo_sum = {1'b0, rs_val[30:0]} + {1'b0, rt_val[30:0]};
  wire c30 = lo_sum[31];
  wire c31 = (rs_val[31] & rt_val[31]) | (c30 & (rs_val[31] ^ rt_val[31]));
  wire s31 = rs_val[31] ^ rt_val[31] ^ c30;
  wire add_ovf = c30 ^ c31;
  wire [63:0] add_res = {{32{s31}}, s31, lo_sum[30:0]};
  wire [63:0] pc_p4 = pc_reg + 64'h4;
  wire [63:0] pc_p8 = pc_reg + 64'h8;
  wire [63:0] br_tgt = pc_p4 + {imm_sx[61:0], 2'b00};
  wire [63:0] j_tgt = {pc_p4[63:28], ir_reg[25:0], 2'b00};
  wire [63:0] va_sum = rs_val + imm_sx;
  // Outside 64-bit mode addresses are sign-extended 32-bit values
  wire [63:0] va_eff = m64_reg ? va_sum : {{32{va_sum[31]}}, va_sum[31:0]};
  wire rs_eq_rt = (rs_val == rt_val);
  wire br_taken = is_j || is_jal || is_jr || is_jalr || (is_beq && rs_eq_rt) || (is_bne && !rs_eq_rt);
  wire [63:0] tgt_sel = (is_jr || is_jalr) ? rs_val : ((is_j || is_jal) ? j_tgt : br_tgt);

  // ----------------------------------------------------------------
  // Sequencing conditions
  // ----------------------------------------------------------------
  wire in_fetch = (state_reg == CLC_S_FETCH);
  wire in_exec = (state_reg == CLC_S_EXEC);
  wire in_xlat = (state_reg == CLC_S_XLAT);
  // Any use of the pending load's register; jal links into r31, jalr into rd
  wire uses_ld = (rs_f == ld_rt_reg) || (rt_f == ld_rt_reg) || (rd_f == ld_rt_reg) ||
                 (is_link && (ld_rt_reg == `CLC_LINK_REG));
  wire hazard = ld_pend_reg && (ld_rt_reg != 5'h00) && uses_ld;
  wire stall = hazard || ((is_load || is_store) && mem_req);
  wire go = in_exec && !stall;
  wire ex_ri = go && !known;
  wire ex_cpu = go && is_copmem;
  wire ex_ov = go && is_add && add_ovf;
  wire exec_exc = ex_ri || ex_cpu || ex_ov;
  wire start_mem = go && (is_load || is_store);
  wire [7:0] lane_be;
  wire [63:0] lane_st;
  wire [63:0] lane_ld;
  wire lane_span;
  wire xl_fault = in_xlat && (!xlat_hit || lane_span);
  wire xl_ok = in_xlat && !xl_fault;
  // Jump target with low bits set faults when it is fetched
  wire fetch_bad = in_fetch && !fetch_req && (pc_reg[1:0] != 2'b00);
  wire take_exc = exec_exc || xl_fault || fetch_bad;
  wire retire = (go && !exec_exc && !start_mem) || xl_ok;
  wire [4:0] exc_sel = ex_ov ? `CLC_EXC_OVERFLOW :
                       ex_cpu ? `CLC_EXC_UNUSABLE :
                       ex_ri ? `CLC_EXC_RESERVED :
                       fetch_bad ? `CLC_EXC_ADDR_LD :
                       lane_span ? (op_store_reg ? `CLC_EXC_ADDR_ST : `CLC_EXC_ADDR_LD) :
                       (op_store_reg ? `CLC_EXC_XLAT_ST : `CLC_EXC_XLAT_LD);
  wire ld_done = mem_req && mem_ack && !mem_we;
  wire ex_wr = go && !exec_exc && ((is_add && !add_ovf) || is_link || is_mf);
  wire [4:0] ex_idx = is_jal ? `CLC_LINK_REG : (is_mf ? rt_f : rd_f);
  wire [63:0] scu_rd = (rd_f == `CLC_SCU_ERA_IDX) ? exception_return_address : 64'h0;
  wire [63:0] ex_val = is_link ? pc_p8 : (is_mf ? scu_rd : add_res);

  // ----------------------------------------------------------------
  // Byte lane selection
  // ----------------------------------------------------------------
  clc_lane_sel u_lane (
    .addr_lo(xlat_vaddr[2:0]),
    .acc_type(op_type_reg),
    .st_data(st_data_reg),
    .ld_dword(mem_rdata),
    .byte_en(lane_be),
    .st_lanes(lane_st),
    .ld_value(lane_ld),
    .span_err(lane_span)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CLC_S_FETCH:
        if (fetch_bad)
          state_next = CLC_S_FETCH;
        else if (fetch_req && fetch_valid)
          state_next = CLC_S_EXEC;
      CLC_S_EXEC:
        if (start_mem)
          state_next = CLC_S_XLAT;
        else if (go)
          state_next = CLC_S_FETCH;
      CLC_S_XLAT:
        state_next = CLC_S_FETCH;
      default:
        state_next = CLC_S_FETCH;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m64_s1_reg <= 1'b0;
      m64_reg <= 1'b0;
    end
    else
    begin
      m64_s1_reg <= mode64_pin;
      m64_reg <= m64_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer, fetch port and delay slot tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= CLC_S_FETCH;
      pc_reg <= RESET_PC;
      ir_reg <= 32'h0;
      fetch_req <= 1'b0;
      fetch_addr <= 64'h0;
      slot_reg <= 1'b0;
      slot_tgt_reg <= 64'h0;
      slot_bpc_reg <= 64'h0;
    end
    else
    begin
      state_reg <= state_next;
      // Raise a fetch of an aligned pc, drop it when the word arrives
      if (in_fetch && !fetch_req && !fetch_bad)
      begin
        fetch_req <= 1'b1;
        fetch_addr <= pc_reg;
      end
      else if (fetch_req && fetch_valid)
      begin
        fetch_req <= 1'b0;
        ir_reg <= fetch_word;
      end
      if (take_exc)
      begin
        pc_reg <= EXC_VECTOR;
        slot_reg <= 1'b0;
      end
      else if (retire)
      begin
        // Slot instruction done: go to the branch outcome
        pc_reg <= slot_reg ? slot_tgt_reg : pc_p4;
        slot_reg <= is_branch && !in_xlat;
        slot_tgt_reg <= br_taken ? tgt_sel : pc_p8;
        slot_bpc_reg <= pc_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Translation and memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xlat_vaddr <= 64'h0;
      op_store_reg <= 1'b0;
      op_type_reg <= 3'h0;
      st_data_reg <= 64'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 64'h0;
      mem_be <= 8'h00;
      mem_wdata <= 64'h0;
      mem_cacheable <= 1'b0;
      mem_fill <= 1'b0;
      ld_pend_reg <= 1'b0;
      ld_rt_reg <= 5'h00;
    end
    else
    begin
      if (start_mem)
      begin
        xlat_vaddr <= va_eff;
        op_store_reg <= is_store;
        op_type_reg <= opc[2:0];
        st_data_reg <= rt_val;
      end
      if (xl_ok)
      begin
        // Whole doubleword fill for cacheable loads
        mem_req <= 1'b1;
        mem_we <= op_store_reg;
        mem_addr <= {xlat_paddr[63:3], 3'b000};
        mem_be <= (!op_store_reg && xlat_cacheable) ? 8'hff : lane_be;
        mem_wdata <= lane_st;
        mem_cacheable <= xlat_cacheable;
        mem_fill <= !op_store_reg && xlat_cacheable;
        ld_pend_reg <= !op_store_reg;
        ld_rt_reg <= rt_f;
      end
      else if (mem_req && mem_ack)
      begin
        mem_req <= 1'b0;
        ld_pend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception reporting, return address and retire strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_valid <= 1'b0;
      exc_code <= 5'h00;
      exc_in_slot <= 1'b0;
      exception_return_address <= 64'h0;
      retire_valid <= 1'b0;
      retire_pc <= 64'h0;
    end
    else
    begin
      exc_valid <= take_exc;
      retire_valid <= retire;
      retire_pc <= pc_reg;
      if (take_exc)
      begin
        exc_code <= exc_sel;
        exc_in_slot <= slot_reg;
        // Restart from the branch when the slot instruction faulted
        exception_return_address <= slot_reg ? slot_bpc_reg : pc_reg;
      end
      else if (go && is_mt && (rd_f == `CLC_SCU_ERA_IDX))
        exception_return_address <= rt_val;
    end
  end

  // ----------------------------------------------------------------
  // Register file writes; the executing instruction wins a collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (ld_done && (ld_rt_reg != 5'h00))
      gpr_mem[ld_rt_reg] <= lane_ld;
    if (ex_wr && (ex_idx != 5'h00))
      gpr_mem[ex_idx] <= ex_val;
  end
endmodule
`default_nettype wire

// *** logic/clc_cfg.svh ***
// Notes on behaviour
// - Stall dependent instruction directly after a load.
// - Translate every access; missing entry raises exception. Only loads and stores are translated; fetch addresses go out untranslated.
// - Loads pick bytes; cacheable loads fill whole doubleword.
// - Stores write only the selected bytes.
// - Access-type code plus one gives byte count.
// - Address names lowest, least significant byte.
// - Branches and jumps have one delay slot.
// - Delay-slot exception returns to preceding branch.
// - Misaligned register-jump target faults on fetch.
// - Control unit reachable only by move instructions.
// - Register add writes sum into destination.
// - Add overflow traps, destination left unchanged.
// - 64-bit add result sign-extends bit 31.
// - Register zero reads zero, ignores writes.
`ifndef CLC_CFG_SVH
`define CLC_CFG_SVH

// ----------------------------------------------------------------
// Reset address and exception vector
// ----------------------------------------------------------------
`define CLC_RESET_PC 64'h0000_0000_0000_1000
`define CLC_EXC_VECTOR 64'h0000_0000_0000_0080

// ----------------------------------------------------------------
// Instruction field codes
// ----------------------------------------------------------------
`define CLC_OPC_SPECIAL 6'h00
`define CLC_OPC_J 6'h02
`define CLC_OPC_JAL 6'h03
`define CLC_OPC_BEQ 6'h04
`define CLC_OPC_BNE 6'h05
`define CLC_OPC_SCU 6'h10
`define CLC_FN_ADD 6'h20
`define CLC_FN_JR 6'h08
`define CLC_FN_JALR 6'h09
`define CLC_SCU_MF 5'h00
`define CLC_SCU_MT 5'h04
`define CLC_SCU_ERA_IDX 5'h0e
`define CLC_LINK_REG 5'h1f
`define CLC_LD_GROUP 3'h4
`define CLC_ST_GROUP 3'h5
`define CLC_COPMEM_GROUP 2'h3

// ----------------------------------------------------------------
// Exception codes
// ----------------------------------------------------------------
`define CLC_EXC_ADDR_LD 5'h04
`define CLC_EXC_ADDR_ST 5'h05
`define CLC_EXC_XLAT_LD 5'h02
`define CLC_EXC_XLAT_ST 5'h03
`define CLC_EXC_UNUSABLE 5'h0b
`define CLC_EXC_RESERVED 5'h0a
`define CLC_EXC_OVERFLOW 5'h0c

`endif

// *** logic/clc_pkg.sv ***
package clc_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    CLC_S_FETCH,
    CLC_S_EXEC,
    CLC_S_XLAT
  } clc_state_t;
  // Exception cause code
  typedef logic [4:0] clc_exc_t;
endpackage

// *** logic/clc_lane_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module clc_lane_sel (
  input wire logic [2:0] addr_lo,
  input wire logic [2:0] acc_type,
  input wire logic [63:0] st_data,
  input wire logic [63:0] ld_dword,
  output logic [7:0] byte_en,
  output logic [63:0] st_lanes,
  output logic [63:0] ld_value,
  output logic span_err
);
  // ----------------------------------------------------------------
  // Span of the item inside the doubleword
  // ----------------------------------------------------------------
  // Highest byte index touched; bit 3 set means the item leaves the doubleword
  wire [3:0] last_byte = {1'b0, addr_lo} + {1'b0, acc_type};
  wire [5:0] lane_shift = {addr_lo, 3'b000};
  wire [63:0] ld_shift = ld_dword >> lane_shift;
  assign span_err = last_byte[3];
  // Store data moves up so its low byte lands at the addressed byte
  assign st_lanes = st_data << lane_shift;

  // ----------------------------------------------------------------
  // Per-byte enables and load extraction
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_lane
      // Enable from addressed byte up to code-plus-one bytes
      assign byte_en[i] = (4'(i) >= {1'b0, addr_lo}) && (4'(i) <= last_byte);
      // Right-aligned load value, zero above the item size
      assign ld_value[8*i +: 8] = (3'(i) <= acc_type) ? ld_shift[8*i +: 8] : 8'h00;
    end
  endgenerate
endmodule
`default_nettype wire

// *** sim/clc_core_ctl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module clc_core_ctl_asserts
  import clc_pkg::*;
#(
  parameter logic [63:0] RESET_PC = 64'h0000_0000_0000_1000,
  parameter logic [63:0] EXC_VECTOR = 64'h0000_0000_0000_0080
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode64_pin,
  input wire logic fetch_req,
  input wire logic [63:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_word,
  input wire logic [63:0] xlat_vaddr,
  input wire logic xlat_hit,
  input wire logic [63:0] xlat_paddr,
  input wire logic xlat_cacheable,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [63:0] mem_addr,
  input wire logic [7:0] mem_be,
  input wire logic [63:0] mem_wdata,
  input wire logic mem_cacheable,
  input wire logic mem_fill,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  input wire logic exc_valid,
  input wire logic [4:0] exc_code,
  input wire logic exc_in_slot,
  input wire logic [63:0] exception_return_address,
  input wire logic retire_valid,
  input wire logic [63:0] retire_pc
);
  // ----
  // Handshake, alignment, fill, exception vector and reset fetch checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Fetch taken by the far side
  sequence fetch_taken_s;
    fetch_req && fetch_valid;
  endsequence
  // Memory access still waiting
  sequence mem_wait_s;
    mem_req && !mem_ack;
  endsequence
  fetch_hold_a: assert property (fetch_req && !fetch_valid |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request changed before answer");
  fetch_drop_a: assert property (fetch_taken_s |=> !fetch_req)
    else $error("fetch request kept after answer");
  mem_hold_a: assert property (mem_wait_s |=> mem_req && $stable({mem_we, mem_addr, mem_be, mem_wdata}))
    else $error("memory request changed before ack");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request kept after ack");
  line_align_a: assert property (mem_req |-> mem_addr[2:0] == 3'h0)
    else $error("memory address not doubleword aligned");
  fill_whole_a: assert property (mem_req && !mem_we && mem_cacheable |-> mem_be == 8'hff && mem_fill)
    else $error("cacheable load does not fill whole line");
  lane_run_a: assert property (mem_req && mem_we |->
    mem_be != 8'h0 && ((mem_be + (mem_be & (~mem_be + 8'h1))) & mem_be) == 8'h0 && !mem_fill)
    else $error("store lanes not one contiguous run");
  fetch_align_a: assert property (fetch_req |-> fetch_addr[1:0] == 2'h0)
    else $error("misaligned fetch issued");
  vector_jump_a: assert property (exc_valid |-> ##[0:8] (fetch_req && fetch_addr == EXC_VECTOR))
    else $error("no fetch from exception vector");
  reset_start_a: assert property (!$past(rst_n) && rst_n |=> fetch_req && fetch_addr == RESET_PC)
    else $error("first fetch not at reset address");
endmodule
bind clc_core_ctl clc_core_ctl_asserts #(.RESET_PC(RESET_PC), .EXC_VECTOR(EXC_VECTOR)) chk_u (.*);
`default_nettype wire

// *** sim/clc_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module clc_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire logic fetch_req,
  input wire logic [63:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] fetch_word,
  input wire logic [63:0] xlat_vaddr,
  output logic xlat_hit,
  output logic [63:0] xlat_paddr,
  output logic xlat_cacheable,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [63:0] mem_addr,
  input wire logic [7:0] mem_be,
  input wire logic [63:0] mem_wdata,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  // ----
  // Storage and store log
  // ----
  logic [31:0] imem [0:63]; // Words from 0x1000 and 0x80
  logic [63:0] dmem [0:31]; // Data doublewords
  logic [1:0] wait_reg; // Cycles waited on a request
  logic [7:0] st_n; // Stores seen
  logic [63:0] st_a;
  logic [7:0] st_be;
  logic [63:0] st_d;
  wire logic [31:0] word_sel = imem[fetch_addr[7:2]];
  wire logic [63:0] line_sel = dmem[mem_addr[7:3]];
  // Outside a valid cycle the buses show inverted data
  assign fetch_word = fetch_valid ? word_sel : ~word_sel;
  assign mem_rdata = mem_ack ? line_sel : ~line_sel;
  // Small table: only the low page maps, bit 6 marks cacheable
  assign xlat_hit = xlat_vaddr[63:8] == 56'h0;
  assign xlat_paddr = xlat_vaddr;
  assign xlat_cacheable = xlat_vaddr[6];
  // Answers fetches next cycle, memory after lat extra cycles
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_valid <= 1'b0;
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      st_n <= 8'h0;
    end
    else
    begin
      fetch_valid <= fetch_req && !fetch_valid;
      mem_ack <= mem_req && !mem_ack && wait_reg == lat;
      wait_reg <= (mem_req && !mem_ack && wait_reg != lat) ? wait_reg + 2'h1 : 2'h0;
      // Store writes only enabled lanes
      if (mem_req && mem_ack && mem_we)
      begin
        for (int i = 0; i < 8; i++)
          if (mem_be[i])
            dmem[mem_addr[7:3]][8*i +: 8] <= mem_wdata[8*i +: 8];
        st_n <= st_n + 8'h1;
        st_a <= mem_addr;
        st_be <= mem_be;
        st_d <= mem_wdata;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import clc_pkg::*;
  // ----
  // Scenario table: program, data, expected code (1f means one store), lanes, address, value
  // ----
  typedef struct packed {
    logic [127:0] w;
    logic [63:0] d0;
    logic [63:0] d1;
    logic [4:0] code;
    logic [7:0] be;
    logic [7:0] a;
    logic [63:0] v;
  } clc_row_t;
  localparam logic [127:0] ADD_PROG = 128'h9c01_0000_9c02_0008_0022_1820_bc03_0010;
  clc_row_t tab [17] = '{
    '{ADD_PROG, 64'h1, 64'h2, 5'h1f, 8'hff, 8'h10, 64'h3},
    '{ADD_PROG, 64'h7fff_ffff, 64'h1, 5'h0c, 8'h0, 8'h0, 64'h1008},
    '{ADD_PROG, 64'hffff_ffff_8000_0000, 64'hffff_ffff_ffff_ffff, 5'h0c, 8'h0, 8'h0, 64'h1008},
    '{ADD_PROG, 64'hffff_ffff_ffff_ffff, 64'h1, 5'h1f, 8'hff, 8'h10, 64'h0},
    '{ADD_PROG, 64'h4000_0000, 64'h3fff_ffff, 5'h1f, 8'hff, 8'h10, 64'h7fff_ffff},
    '{ADD_PROG, 64'hffff_ffff_8000_0000, 64'h7fff_ffff, 5'h1f, 8'hff, 8'h10, 64'hffff_ffff_ffff_ffff},
    '{128'h9c01_0000_9c02_0008_0022_0020_bc00_0010, 64'h5, 64'h6, 5'h1f, 8'hff, 8'h10, 64'h0},
    '{128'h9c01_0100_0000_0020_0000_0020_0000_0020, 64'h0, 64'h0, 5'h02, 8'h0, 8'h0, 64'h1000},
    '{128'hbc01_0100_0000_0020_0000_0020_0000_0020, 64'h0, 64'h0, 5'h03, 8'h0, 8'h0, 64'h1000},
    '{128'h0800_0404_9c01_0100_0000_0020_0000_0020, 64'h0, 64'h0, 5'h02, 8'h0, 8'h0, 64'h1000},
    '{128'h0800_0403_bc00_0010_bc00_0018_0000_0020, 64'h0, 64'h0, 5'h1f, 8'hff, 8'h10, 64'h0},
    '{128'h0c00_0403_0000_0020_bc00_0018_bc1f_0010, 64'h0, 64'h0, 5'h1f, 8'hff, 8'h10, 64'h1008},
    '{128'h9c01_0000_1420_0002_bc01_0010_bc00_0018, 64'h55, 64'h0, 5'h1f, 8'hff, 8'h10, 64'h55},
    '{128'h9c01_0000_0020_0008_0000_0020_0000_0020, 64'h1002, 64'h0, 5'h04, 8'h0, 8'h0, 64'h1002},
    '{128'hc001_0000_0000_0020_0000_0020_0000_0020, 64'h0, 64'h0, 5'h0b, 8'h0, 8'h0, 64'h1000},
    '{128'h9c01_0000_4081_7000_4002_7000_bc02_0010, 64'h1234, 64'h0, 5'h1f, 8'hff, 8'h10, 64'h1234},
    '{ADD_PROG, 64'h8, 64'h7fff_fff8, 5'h0c, 8'h0, 8'h0, 64'h1008}
  };
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode64_pin = 1'b0;
  logic [1:0] lat = 2'h0; // Memory latency of the model
  logic fetch_req, fetch_valid, xlat_hit, xlat_cacheable, mem_req, mem_we, mem_cacheable, mem_fill;
  logic mem_ack, exc_valid, exc_in_slot, retire_valid, exc_seen, halt_seen;
  logic [4:0] exc_code;
  logic [7:0] mem_be;
  logic [31:0] fetch_word;
  logic [63:0] fetch_addr, xlat_vaddr, xlat_paddr, mem_addr, mem_wdata, mem_rdata, exception_return_address, retire_pc;
  int fails = 0;
  int cmp_count = 0;
  clc_core_ctl dut_u (.*);
  clc_mem_model mem_u (.*);
  always #4 clk = ~clk;
  // Notes exceptions and arrival at the halt loop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_seen <= 1'b0;
      halt_seen <= 1'b0;
    end
    else
    begin
      if (exc_valid === 1'b1)
        exc_seen <= 1'b1;
      if (retire_valid === 1'b1 && retire_pc === 64'h1014)
        halt_seen <= 1'b1;
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic final_report;
  begin
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // Store of r1 loaded whole, into lanes ending at byte 7
  function automatic clc_row_t row_st(input int t);
    clc_row_t r;
    r.w = {32'h9c01_0000, 3'h5, t[2:0], 10'h001, 16'h0047 - t[15:0], 64'h0000_0020_0000_0020};
    r.d0 = 64'h8877_6655_4433_2211;
    r.d1 = 64'h0;
    r.code = 5'h1f;
    r.be = 8'hff << (7 - t);
    r.a = 8'h40;
    r.v = r.d0 << (8 * (7 - t));
    return r;
  endfunction
  // Sized load, odd access-type codes cacheable, then whole store of r1
  function automatic clc_row_t row_ld(input int t);
    clc_row_t r;
    r.w = {3'h4, t[2:0], 10'h001, 16'h000f - t[15:0] + (t[0] ? 16'h0040 : 16'h0000), 32'hbc01_0010, 64'h20_0000_0020};
    r.d0 = 64'h0;
    r.d1 = 64'hf0e1_d2c3_b4a5_9687;
    r.code = 5'h1f;
    r.be = 8'hff;
    r.a = 8'h10;
    r.v = r.d1 >> (8 * (7 - t));
    return r;
  endfunction
  // Loads a program, resets, runs to halt or exception and compares
  task automatic run(input clc_row_t r, input int n);
    int i;
    logic [63:0] m;
  begin
    @(negedge clk);
    rst_n = 1'b0;
    for (i = 0; i < 4; i++)
      mem_u.imem[i] = r.w[127 - 32 * i -: 32];
    mem_u.imem[4] = 32'h0800_0404;
    mem_u.imem[5] = 32'h0000_0020;
    mem_u.imem[32] = 32'h0800_0020;
    mem_u.imem[33] = 32'h0000_0020;
    mem_u.dmem[0] = r.d0;
    mem_u.dmem[1] = r.d1;
    mem_u.dmem[9] = r.d1;
    mode64_pin = n[0];
    lat = n[2:1];
    repeat (20) @(negedge clk);
    check({60'h0, fetch_req, mem_req, exc_valid, retire_valid}, 64'h0);
    rst_n = 1'b1;
    for (i = 0; i < 400 && !(exc_seen || (halt_seen && mem_req === 1'b0)); i++)
      @(negedge clk);
    if (i == 400)
    begin
      fails++;
      final_report();
    end
    for (i = 0; i < 8; i++)
      m[8*i +: 8] = {8{r.be[i]}};
    check(mem_u.st_n, (r.code == 5'h1f) ? 64'h1 : 64'h0);
    check(exc_seen, r.code != 5'h1f);
    if (r.code == 5'h1f)
    begin
      check(mem_u.st_a, {56'h0, r.a});
      check(mem_u.st_be, r.be);
      check(mem_u.st_d & m, r.v & m);
    end
    else
    begin
      check(exc_code, r.code);
      check(exception_return_address, r.v);
      check(exc_in_slot, r.w[127:122] == 6'h02);
    end
  end
  endtask
  initial
  begin
    for (int r = 0; r < 17; r++)
      run(tab[r], r);
    for (int t = 0; t < 8; t++)
    begin
      run(row_st(t), t);
      run(row_ld(t), t + 3);
    end
    final_report();
  end
endmodule
`default_nettype wire
